// *** hdl/cpu_address_alu_decode.sv ***
// Purpose: Fetch, effective-address, memory-reference and two-accumulator execution
// Assumes: Memory answers each request with one ack pulse, same clock domain
// Notes:   Stack, multiply/divide and I/O words execute as no-operations
// Summary of operation
// - Indirect bit set: fetch word; bit 0 clear ends chain, else chain continues
// - Indirection counter cleared at start, +2 per word, +3 auto; halt past 17
// - Indirect through octal 20-27 increments word, writes back, uses new value
// - Indirect through octal 30-37 decrements word, writes back, uses new value
// - Auto locations: chain continues on bit 0 before the update
// - Read of absent memory returns all ones
// - Index 00 page zero, 01 PC relative, 10 accumulator two, 11 three
// - Leading 000 words are no-accumulator ops; jump loads effective address
// - Subroutine call puts PC+1 in accumulator three, bit 0 clear, then jumps
// - Increment/decrement-skip writes back; PC advances two on zero, else one
// - Bits 3-4 pick accumulator; load reads memory, store writes it
// - Trap stores its own address at octal 46, then jumps indirect via 47
// - Bit 0 set: two-accumulator op, bits 1-2 source, 3-4 destination
// - Function generator yields 17-bit carry plus result for the shifter
// - Carry field: keep, zero, one, or complement before the operation
// - Shift field: pass, rotate left, rotate right, swap bytes keeping carry
// - Skip sensor tests shifter carry/result and adds one extra PC step
// - No-load bit set keeps destination accumulator and carry
// - Skip codes: never, always, cz, cnz, rz, rnz, either zero, both nonzero
// - Non-absolute modes add signed 8-bit displacement to the base
// - Effective address sums wrap at 15 bits
`timescale 1ns/1ps
`default_nettype none
module cpu_address_alu_decode (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      srst,
    // Memory bus
    output cpu_decode_pkg::mem_req_t       mem_req,
    input  wire cpu_decode_pkg::mem_rsp_t  mem_rsp,
    // Status
    output cpu_decode_pkg::cpu_stat_t      status,
    output logic [15:0]                    accumulator_two,
    output logic [15:0]                    accumulator_three
);
    // ---------------------------------------------------------------
    // State machine
    // ---------------------------------------------------------------
    typedef enum logic [6:0] {
        S_FETCH = 7'h01, S_DECODE = 7'h02, S_IND = 7'h04, S_AUTO_WR = 7'h08,
        S_OPER = 7'h10, S_RMW_WR = 7'h20, S_HALT = 7'h40
    } state_t;

    state_t      state_r, state_nxt;
    logic [15:0] ac_r [4];
    logic [15:0] ac_nxt [4];
    logic [14:0] pc_r, pc_nxt;
    logic [15:0] ir_r, ir_nxt;
    logic        carry_r, carry_nxt;
    logic [4:0]  ind_cnt_r, ind_cnt_nxt;
    logic [14:0] ea_r, ea_nxt;
    logic [15:0] hold_r, hold_nxt;
    logic        trap_r, trap_nxt;
    cpu_decode_pkg::mem_req_t req_r, req_nxt;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    wire [15:0] rdata     = mem_rsp.present ? mem_rsp.rdata : cpu_decode_pkg::ALL_ONES;
    wire        ack       = mem_rsp.ack;
    wire        is_alu    = ir_r[15];
    // Trap reuses the no-load, never-skip pattern; the trap number is ignored
    wire        is_trap   = is_alu && ir_r[2:0] == cpu_decode_pkg::SK_NEVER
                            && ir_r[3] == 1'b1;
    wire [2:0]  cls       = ir_r[15:13];
    wire [1:0]  acsel     = ir_r[12:11];
    wire        ind_bit   = ir_r[10];
    wire [1:0]  idx       = ir_r[9:8];
    wire [7:0]  disp      = ir_r[7:0];
    wire [14:0] disp_sx   = {{7{disp[7]}}, disp};
    wire [14:0] idx_base  = (idx == cpu_decode_pkg::IDX_PC)  ? pc_r :
                            (idx == cpu_decode_pkg::IDX_AC2) ? ac_r[2][14:0] :
                            ac_r[3][14:0];
    // Page zero uses an unsigned displacement; others wrap at 15 bits
    wire [14:0] ea_calc   = (idx == cpu_decode_pkg::IDX_ABS) ? {7'h00, disp}
                            : idx_base + disp_sx;
    wire        auto_inc  = ea_r >= cpu_decode_pkg::AUTO_INC_LO && ea_r <= cpu_decode_pkg::AUTO_INC_HI;
    wire        auto_dec  = ea_r >= cpu_decode_pkg::AUTO_DEC_LO && ea_r <= cpu_decode_pkg::AUTO_DEC_HI;
    wire [15:0] auto_val  = auto_inc ? rdata + cpu_decode_pkg::ONE16
                                     : rdata - cpu_decode_pkg::ONE16;
    wire [15:0] chain_val = (auto_inc || auto_dec) ? auto_val : rdata;
    wire [4:0]  ind_add   = (auto_inc || auto_dec) ? cpu_decode_pkg::IND_STEP_AUTO
                                                   : cpu_decode_pkg::IND_STEP;
    wire [4:0]  ind_sum   = ind_cnt_r + ind_add;

    // Two-accumulator datapath
    wire [15:0] src       = ac_r[ir_r[14:13]];
    wire [15:0] dst       = ac_r[ir_r[12:11]];
    wire [2:0]  fn        = ir_r[10:8];
    wire [1:0]  shf       = ir_r[7:6];
    wire [1:0]  cyf       = ir_r[5:4];
    wire        noload    = ir_r[3];
    wire [2:0]  skf       = ir_r[2:0];
    wire        cy0       = (cyf == cpu_decode_pkg::CY_KEEP) ? carry_r :
                            (cyf == cpu_decode_pkg::CY_ZERO) ? 1'b0 :
                            (cyf == cpu_decode_pkg::CY_ONE)  ? 1'b1 : ~carry_r;
    wire [16:0] sum_com   = {1'b0, ~src};
    wire [16:0] sum_neg   = {1'b0, ~src} + 17'h00001;
    wire [16:0] sum_inc   = {1'b0, src} + 17'h00001;
    wire [16:0] sum_adc   = {1'b0, dst} + {1'b0, ~src};
    wire [16:0] sum_sub   = {1'b0, dst} + {1'b0, ~src} + 17'h00001;
    wire [16:0] sum_add   = {1'b0, dst} + {1'b0, src};
    wire [16:0] fg_raw    = (fn == cpu_decode_pkg::FN_COM) ? sum_com :
                            (fn == cpu_decode_pkg::FN_NEG) ? sum_neg :
                            (fn == cpu_decode_pkg::FN_MOV) ? {1'b0, src} :
                            (fn == cpu_decode_pkg::FN_INC) ? sum_inc :
                            (fn == cpu_decode_pkg::FN_ADC) ? sum_adc :
                            (fn == cpu_decode_pkg::FN_SUB) ? sum_sub :
                            (fn == cpu_decode_pkg::FN_ADD) ? sum_add :
                            {1'b0, src & dst};
    wire [16:0] fg_out    = {cy0 ^ fg_raw[16], fg_raw[15:0]};
    wire [16:0] sh_out    = (shf == cpu_decode_pkg::SH_LEFT)  ? {fg_out[15:0], fg_out[16]} :
                            (shf == cpu_decode_pkg::SH_RIGHT) ? {fg_out[0], fg_out[16:1]} :
                            (shf == cpu_decode_pkg::SH_SWAP)  ?
                                {fg_out[16], fg_out[7:0], fg_out[15:8]} : fg_out;
    wire        cz        = ~sh_out[16];
    wire        rz        = sh_out[15:0] == 16'h0000;
    wire        skip      = (skf == cpu_decode_pkg::SK_ALWAYS) ||
                            (skf == cpu_decode_pkg::SK_CZ  && cz)  ||
                            (skf == cpu_decode_pkg::SK_CNZ && !cz) ||
                            (skf == cpu_decode_pkg::SK_RZ  && rz)  ||
                            (skf == cpu_decode_pkg::SK_RNZ && !rz) ||
                            (skf == cpu_decode_pkg::SK_EZ  && (cz || rz)) ||
                            (skf == cpu_decode_pkg::SK_BN  && !cz && !rz);
    wire [14:0] pc_inc    = pc_r + cpu_decode_pkg::ONE15;
    wire [14:0] pc_skip   = pc_r + cpu_decode_pkg::TWO15;
    wire [15:0] rmw_val   = (acsel == cpu_decode_pkg::increment_skip_zero_op)
                            ? rdata + cpu_decode_pkg::ONE16 : rdata - cpu_decode_pkg::ONE16;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_nxt   = state_r;
        pc_nxt      = pc_r;
        ir_nxt      = ir_r;
        carry_nxt   = carry_r;
        ind_cnt_nxt = ind_cnt_r;
        ea_nxt      = ea_r;
        hold_nxt    = hold_r;
        trap_nxt    = trap_r;
        req_nxt     = req_r;
        for (int i = 0; i < 4; i++) begin
            ac_nxt[i] = ac_r[i];
        end
        case (state_r)
            S_FETCH: begin
                if (!req_r.rd) begin
                    req_nxt = '{rd: 1'b1, wr: 1'b0, addr: pc_r, wdata: 16'h0000};
                end else if (ack) begin
                    req_nxt.rd = 1'b0;
                    ir_nxt     = rdata;
                    state_nxt  = S_DECODE;
                end
            end
            S_DECODE: begin
                trap_nxt    = 1'b0;
                ind_cnt_nxt = 5'h00;
                if (is_alu && !is_trap) begin
                    carry_nxt = noload ? carry_r : sh_out[16];
                    if (!noload) begin
                        ac_nxt[ir_r[12:11]] = sh_out[15:0];
                    end
                    pc_nxt    = skip ? pc_skip : pc_inc;
                    state_nxt = S_FETCH;
                end else if (is_trap) begin
                    // Save own address, then chain through the vector word
                    req_nxt   = '{rd: 1'b0, wr: 1'b1, addr: cpu_decode_pkg::TRAP_SAVE,
                                  wdata: {1'b0, pc_r}};
                    ea_nxt    = cpu_decode_pkg::TRAP_VECTOR;
                    trap_nxt  = 1'b1;
                    state_nxt = S_AUTO_WR;
                end else if (cls == cpu_decode_pkg::NOACC_CLASS || cls == load_or_store(cls)) begin
                    ea_nxt = ea_calc;
                    if (ind_bit) begin
                        req_nxt   = '{rd: 1'b1, wr: 1'b0, addr: ea_calc, wdata: 16'h0000};
                        state_nxt = S_IND;
                    end else begin
                        state_nxt = S_OPER;
                    end
                end else begin
                    pc_nxt    = pc_inc;
                    state_nxt = S_FETCH;
                end
            end
            S_IND: begin
                if (ack) begin
                    req_nxt.rd  = 1'b0;
                    ind_cnt_nxt = ind_sum;
                    ea_nxt      = chain_val[14:0];
                    if (ind_sum > cpu_decode_pkg::IND_LIMIT) begin
                        state_nxt = S_HALT;
                    end else begin
                        if (auto_inc || auto_dec) begin
                            req_nxt = '{rd: 1'b0, wr: 1'b1, addr: ea_r, wdata: auto_val};
                        end
                        // Continue from the bit 0 seen before any update
                        hold_nxt  = {rdata[15], 15'h0000};
                        state_nxt = (auto_inc || auto_dec) ? S_AUTO_WR
                                    : rdata[15] ? S_IND : S_OPER;
                        if (!(auto_inc || auto_dec) && rdata[15]) begin
                            req_nxt = '{rd: 1'b1, wr: 1'b0, addr: chain_val[14:0],
                                        wdata: 16'h0000};
                        end
                    end
                end
            end
            S_AUTO_WR: begin
                // Write-back done; trap resumes with an indirect read of its vector
                if (ack) begin
                    req_nxt.wr = 1'b0;
                    if (trap_r || hold_r[15]) begin
                        req_nxt   = '{rd: 1'b1, wr: 1'b0, addr: ea_r, wdata: 16'h0000};
                        trap_nxt  = 1'b0;
                        state_nxt = S_IND;
                    end else begin
                        state_nxt = S_OPER;
                    end
                end
            end
            S_OPER: begin
                if (cls == cpu_decode_pkg::NOACC_CLASS && !is_alu
                    && acsel == cpu_decode_pkg::jump_op) begin
                    pc_nxt    = ea_r;
                    state_nxt = S_FETCH;
                end else if (cls == cpu_decode_pkg::NOACC_CLASS && !is_alu
                             && acsel == cpu_decode_pkg::subroutine_call_op) begin
                    ac_nxt[3] = {1'b0, pc_inc};
                    pc_nxt    = ea_r;
                    state_nxt = S_FETCH;
                end else if (is_alu) begin
                    pc_nxt    = ea_r;
                    state_nxt = S_FETCH;
                end else if (cls == cpu_decode_pkg::store_accumulator_op) begin
                    if (!req_r.wr) begin
                        req_nxt = '{rd: 1'b0, wr: 1'b1, addr: ea_r, wdata: ac_r[acsel]};
                    end else if (ack) begin
                        req_nxt.wr = 1'b0;
                        pc_nxt     = pc_inc;
                        state_nxt  = S_FETCH;
                    end
                end else if (!req_r.rd) begin
                    req_nxt = '{rd: 1'b1, wr: 1'b0, addr: ea_r, wdata: 16'h0000};
                end else if (ack) begin
                    req_nxt.rd = 1'b0;
                    if (cls == cpu_decode_pkg::load_accumulator_op) begin
                        ac_nxt[acsel] = rdata;
                        pc_nxt        = pc_inc;
                        state_nxt     = S_FETCH;
                    end else begin
                        req_nxt  = '{rd: 1'b0, wr: 1'b1, addr: ea_r, wdata: rmw_val};
                        hold_nxt = rmw_val;
                        state_nxt = S_RMW_WR;
                    end
                end
            end
            S_RMW_WR: begin
                if (ack) begin
                    req_nxt.wr = 1'b0;
                    pc_nxt     = (hold_r == 16'h0000) ? pc_skip : pc_inc;
                    state_nxt  = S_FETCH;
                end
            end
            S_HALT: state_nxt = S_HALT;
            default: state_nxt = S_FETCH;
        endcase
    end

    // Classes 1 and 2 share the memory-reference path
    function automatic logic [2:0] load_or_store(input logic [2:0] c);
        load_or_store = (c == cpu_decode_pkg::load_accumulator_op) ? c :
                        cpu_decode_pkg::store_accumulator_op;
    endfunction : load_or_store

    // State registers
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= S_FETCH;
            pc_r    <= cpu_decode_pkg::RESET_PC;
            req_r   <= '0;
            carry_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pc_r    <= pc_nxt;
            req_r   <= req_nxt;
            carry_r <= carry_nxt;
        end
    end

    // Datapath registers
    always_ff @(posedge clk) begin
        if (srst) begin
            ir_r      <= 16'h0000;
            ind_cnt_r <= 5'h00;
            ea_r      <= 15'h0000;
            hold_r    <= 16'h0000;
            trap_r    <= 1'b0;
            for (int i = 0; i < 4; i++) ac_r[i] <= 16'h0000;
        end else begin
            ir_r      <= ir_nxt;
            ind_cnt_r <= ind_cnt_nxt;
            ea_r      <= ea_nxt;
            hold_r    <= hold_nxt;
            trap_r    <= trap_nxt;
            for (int i = 0; i < 4; i++) ac_r[i] <= ac_nxt[i];
        end
    end

    assign mem_req           = req_r;
    assign status            = '{pc: pc_r, carry: carry_r, halted: state_r == S_HALT};
    assign accumulator_two   = ac_r[2];
    assign accumulator_three = ac_r[3];

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_halt_limit: assert property (@(posedge clk) disable iff (srst)
        state_r == S_IND && ack && ind_sum > cpu_decode_pkg::IND_LIMIT |=> status.halted)
        else $error("counter past limit did not halt");
    a_halt_sticks: assert property (@(posedge clk) disable iff (srst)
        status.halted |=> status.halted [*3])
        else $error("halt released");
    a_jsr_link: assert property (@(posedge clk) disable iff (srst)
        state_r == S_OPER && !is_alu && cls == 3'h0 && acsel == 2'h1
        |=> ac_r[3] == {1'b0, $past(pc_r) + 15'h0001} && pc_r == $past(ea_r))
        else $error("subroutine link wrong");
    a_noload_keep: assert property (@(posedge clk) disable iff (srst)
        state_r == S_DECODE && is_alu && !is_trap && noload
        |=> $stable(carry_r))
        else $error("no-load changed carry");
    a_skip_step: assert property (@(posedge clk) disable iff (srst)
        state_r == S_DECODE && is_alu && !is_trap |=> pc_r == $past(skip ? pc_skip : pc_inc))
        else $error("skip step wrong");
    a_auto_write: assert property (@(posedge clk) disable iff (srst)
        state_r == S_IND && ack && auto_inc && ind_sum <= cpu_decode_pkg::IND_LIMIT
        |=> mem_req.wr && mem_req.wdata == $past(rdata) + 16'h0001)
        else $error("auto increment write wrong");
    a_isz_skip: assert property (@(posedge clk) disable iff (srst)
        state_r == S_RMW_WR && ack && hold_r == 16'h0000 |=> pc_r == $past(pc_r) + 15'h0002)
        else $error("zero result did not skip");
    a_page_zero: assert property (@(posedge clk) disable iff (srst)
        state_r == S_DECODE && !is_alu && cls <= cpu_decode_pkg::store_accumulator_op
        && idx == cpu_decode_pkg::IDX_ABS |=> ea_r == {7'h00, $past(disp)})
        else $error("page zero escaped");
endmodule : cpu_address_alu_decode
`default_nettype wire

// *** hdl/cpu_decode_pkg.sv ***
// Purpose: Constants and types for the address/ALU decode block
// Assumes: Bit 0 is the word's most significant bit, as the instruction set numbers it
// Notes:   Verilog index 15 holds bit 0, index 0 holds bit 15
package cpu_decode_pkg;
    // ---------------------------------------------------------------
    // Widths and addresses
    // ---------------------------------------------------------------
    localparam int          WORD_W       = 16;
    localparam int          ADDR_W       = 15;
    localparam logic [14:0] AUTO_INC_LO  = 15'h0010;
    localparam logic [14:0] AUTO_INC_HI  = 15'h0017;
    localparam logic [14:0] AUTO_DEC_LO  = 15'h0018;
    localparam logic [14:0] AUTO_DEC_HI  = 15'h001F;
    localparam logic [14:0] TRAP_SAVE    = 15'h0026;
    localparam logic [14:0] TRAP_VECTOR  = 15'h0027;
    localparam logic [4:0]  IND_LIMIT    = 5'h11;
    localparam logic [4:0]  IND_STEP     = 5'h02;
    localparam logic [4:0]  IND_STEP_AUTO = 5'h03;
    localparam logic [15:0] ALL_ONES     = 16'hFFFF;
    localparam logic [15:0] ONE16        = 16'h0001;
    localparam logic [14:0] ONE15        = 15'h0001;
    localparam logic [14:0] TWO15        = 15'h0002;
    localparam logic [14:0] RESET_PC     = 15'h0000;

    // Index modes
    localparam logic [1:0] IDX_ABS = 2'h0;
    localparam logic [1:0] IDX_PC  = 2'h1;
    localparam logic [1:0] IDX_AC2 = 2'h2;
    localparam logic [1:0] IDX_AC3 = 2'h3;

    // No-accumulator operations
    localparam logic [1:0] jump_op                 = 2'h0;
    localparam logic [1:0] subroutine_call_op      = 2'h1;
    localparam logic [1:0] increment_skip_zero_op  = 2'h2;
    localparam logic [1:0] decrement_skip_zero_op  = 2'h3;
    // Top three bits of one-accumulator classes and of the no-accumulator class
    localparam logic [2:0] load_accumulator_op     = 3'h1;
    localparam logic [2:0] store_accumulator_op    = 3'h2;
    localparam logic [2:0] NOACC_CLASS             = 3'h0;

    // Carry init, shift field, skip codes
    localparam logic [1:0] CY_KEEP = 2'h0;
    localparam logic [1:0] CY_ZERO = 2'h1;
    localparam logic [1:0] CY_ONE  = 2'h2;
    localparam logic [1:0] CY_COMP = 2'h3;
    localparam logic [1:0] SH_NONE = 2'h0;
    localparam logic [1:0] SH_LEFT = 2'h1;
    localparam logic [1:0] SH_RIGHT = 2'h2;
    localparam logic [1:0] SH_SWAP = 2'h3;
    localparam logic [2:0] SK_NEVER = 3'h0;
    localparam logic [2:0] SK_ALWAYS = 3'h1;
    localparam logic [2:0] SK_CZ   = 3'h2;
    localparam logic [2:0] SK_CNZ  = 3'h3;
    localparam logic [2:0] SK_RZ   = 3'h4;
    localparam logic [2:0] SK_RNZ  = 3'h5;
    localparam logic [2:0] SK_EZ   = 3'h6;
    localparam logic [2:0] SK_BN   = 3'h7;
    // ALU functions
    localparam logic [2:0] FN_COM = 3'h0;
    localparam logic [2:0] FN_NEG = 3'h1;
    localparam logic [2:0] FN_MOV = 3'h2;
    localparam logic [2:0] FN_INC = 3'h3;
    localparam logic [2:0] FN_ADC = 3'h4;
    localparam logic [2:0] FN_SUB = 3'h5;
    localparam logic [2:0] FN_ADD = 3'h6;
    localparam logic [2:0] FN_AND = 3'h7;

    // Memory request carried out to the bus
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [14:0] addr;
        logic [15:0] wdata;
    } mem_req_t;

    // Memory answer
    typedef struct packed {
        logic        ack;
        logic        present;
        logic [15:0] rdata;
    } mem_rsp_t;

    // Architectural state for observation
    typedef struct packed {
        logic [14:0] pc;
        logic        carry;
        logic        halted;
    } cpu_stat_t;
endpackage : cpu_decode_pkg

// *** testbench/word_memory_model.sv ***
// Purpose: Word memory answering the decode block's bus
// Assumes: Addresses at and above ABSENT_LO hold no memory
// Notes:   Read data wanders while no answer stands
`timescale 1ns/1ps
`default_nettype none
module word_memory_model #(
    parameter logic SLOW = 1'b0,
    parameter logic [14:0] ABSENT_LO = 15'h0060
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     srst,
    // Memory bus
    input  wire cpu_decode_pkg::mem_req_t mem_req,
    output cpu_decode_pkg::mem_rsp_t      mem_rsp
);
    logic [15:0] mem [0:127];
    logic        hit;
    logic        pace_r;
    assign hit = mem_req.addr < ABSENT_LO;
    // One-cycle answer, every other cycle when slow; absent words give zero with present low
    always @(posedge clk) begin
        pace_r <= srst ? 1'b0 : ~pace_r;
        if (srst || mem_rsp.ack) begin
            mem_rsp.ack     <= 1'b0;
            mem_rsp.present <= 1'b0;
            mem_rsp.rdata   <= srst ? 16'hA5A5 : ~mem_rsp.rdata;
        end else if ((mem_req.rd || mem_req.wr) && (!SLOW || pace_r)) begin
            mem_rsp.ack     <= 1'b1;
            mem_rsp.present <= hit;
            mem_rsp.rdata   <= hit ? mem[mem_req.addr[6:0]] : 16'h0000;
            if (mem_req.wr && hit) mem[mem_req.addr[6:0]] <= mem_req.wdata;
        end else mem_rsp.rdata <= ~mem_rsp.rdata;
    end
endmodule : word_memory_model
`default_nettype wire

// *** testbench/cpu_address_alu_decode_bench.sv ***
// Purpose: Runs a short program through the decode block and checks results
// Assumes: Memory model answers slowly, program preloaded at time zero
// Notes:   Program ends in a self-pointing indirect chain that must halt
`timescale 1ns/1ps
`default_nettype none
module cpu_address_alu_decode_bench;
    logic                      clk = 1'b0;
    logic                      srst = 1'b1;
    cpu_decode_pkg::mem_req_t  mem_req;
    cpu_decode_pkg::mem_rsp_t  mem_rsp;
    cpu_decode_pkg::cpu_stat_t status;
    logic [15:0]               ac2;
    logic [15:0]               ac3;
    int                        fail_count = 0;
    int                        tests_run = 0;
    logic [31:0] prog [0:21] = '{32'h00003840, 32'h0001350F, 32'h00025043, 32'h00031044,
        32'h00043845, 32'h0005F2E1, 32'h00063845, 32'h00070850, 32'h00401234, 32'h00100041,
        32'h00425555, 32'h0044FFFF, 32'h0045DEAD, 32'h00501DC8, 32'h00513845, 32'h00523060,
        32'h00530055, 32'h00543845, 32'h00550456, 32'h00568056, 32'h00180047, 32'h00460001};
    logic [31:0] rows [0:4] = '{32'h00100042, 32'h00180046, 32'h00435555, 32'h00440000,
        32'h00460000};
    always #5 clk = ~clk;
    cpu_address_alu_decode u_dut (.clk(clk), .srst(srst), .mem_req(mem_req),
        .mem_rsp(mem_rsp), .status(status), .accumulator_two(ac2), .accumulator_three(ac3));
    word_memory_model #(.SLOW(1'b1)) u_mem (.clk(clk), .srst(srst), .mem_req(mem_req),
        .mem_rsp(mem_rsp));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // Bounded wait for a program counter value, or for halt when goal is FFFF
    task automatic wait_for(input logic [15:0] goal);
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk);
            #1;
            if (goal == 16'hFFFF ? status.halted === 1'b1 : status.pc === goal[14:0]) return;
        end
        $display("mismatch wait expected %h seen %h", goal, {1'b0, status.pc});
        fail_count++;
        wrap_up();
    endtask : wait_for
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        foreach (prog[i]) u_mem.mem[prog[i][22:16]] = prog[i][15:0];
        repeat (20) @(posedge clk);
        #1 srst = 1'b0;
        check("reset pc", 16'h0000, {1'b0, status.pc});
        check("reset ac3", 16'h0000, ac3);
        wait_for(16'h0007);
        check("swap ac2", 16'h3412, ac2);
        check("carry set", 16'h0001, {15'h0000, status.carry});
        check("load ac3", 16'h1234, ac3);
        wait_for(16'h0050);
        check("return ac3", 16'h0008, ac3);
        wait_for(16'h0053);
        check("absent ac2", 16'hFFFF, ac2);
        wait_for(16'hFFFF);
        foreach (rows[i]) check("memory word", rows[i][15:0], u_mem.mem[rows[i][22:16]]);
        // Reset out of halt must restart cleanly
        srst = 1'b1;
        @(posedge clk);
        #1 srst = 1'b0;
        check("halt cleared", 16'h0000, {15'h0000, status.halted});
        check("restart pc", 16'h0000, {1'b0, status.pc});
        wrap_up();
    end
endmodule : cpu_address_alu_decode_bench
`default_nettype wire
